// ==== logic/det_map.vh ====
`ifndef DET_MAP_VH
`define DET_MAP_VH
// Clock select codes
`define DET_CSEL_EVT_FALL 4'h0
`define DET_CSEL_EVT_RISE 4'h1
`define DET_CSEL_RST 4'h0
// Internal prescaler tap range: code 4..15 selects divide by 2^(code-4)
`define DET_CSEL_INT_MIN 4'h4
`define DET_PRESC_W 12
`define DET_CMP_RST 8'h00
`define DET_CNT_RST 8'h00
`endif

// ==== logic/det_edge_sync.v ====
`timescale 1ns/1ps
`include "det_map.vh"
module det_edge_sync (
   input wire clk_sys_i,
   input wire srst_i,
   input wire ce_i,
   input wire pin_i,
   output wire rise_o,
   output wire fall_o
);
   reg meta_q;
   reg sync_q;
   reg prev_q;
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce_i) begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   // Edges seen only after two flops; first flop feeds nothing else
   assign rise_o = ce_i & sync_q & ~prev_q;
   assign fall_o = ce_i & ~sync_q & prev_q;
endmodule

// ==== logic/det_timer.v ====
`timescale 1ns/1ps
`include "det_map.vh"
// Overview of operation
// - Starting the counter is not aligned to the count pulse, so the first match may come up to one count clock early, never late.
// - Each compare register accepts zero, which hit_at treats as a match on every tick.
// - In event counting with compare zero, every input pulse produces a match.
// - A compare value written below the current count is passed, the counter wraps through zero and matches on the next pass.
// - In event mode the counter steps on the external input edge chosen rising or falling by the clock select.
// - Outside cascade mode, on the tick that would bring the count to compare the counter clears to zero and a match request is raised.
// - In cascaded mode a low counter match still raises the low request and toggles the low output.
module det_timer #(
   parameter CNT_W = 8
) (
   // Clock, reset, enable
   input wire clk_sys_i,
   input wire srst_i,
   input wire ce_i,
   // Control
   input wire count_enable_bit_i,
   input wire cascade_i,
   input wire [3:0] clock_select_reg_i,
   input wire [3:0] high_clock_select_i,
   input wire low_compare_wr_i,
   input wire high_compare_wr_i,
   input wire [CNT_W-1:0] compare_wdata_i,
   // External pin
   input wire event_input_pin_i,
   // Outputs
   output reg [CNT_W-1:0] low_counter_o,
   output reg [CNT_W-1:0] high_counter_o,
   output reg [CNT_W-1:0] low_compare_o,
   output reg [CNT_W-1:0] high_compare_o,
   output reg low_match_irq_o,
   output reg high_match_irq_o,
   output reg low_timer_output_o,
   output reg high_timer_output_o
);
   // ************************************************
   // Count pulse sources
   // ************************************************
   wire evt_rise;
   wire evt_fall;
   reg [`DET_PRESC_W-1:0] presc_q;
   reg [`DET_PRESC_W-1:0] presc_prev_q;

   det_edge_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .pin_i(event_input_pin_i),
      .rise_o(evt_rise),
      .fall_o(evt_fall)
   );

   // Free running prescaler: it is not cleared on start, hence the start error
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         presc_q <= {`DET_PRESC_W{1'b0}};
         presc_prev_q <= {`DET_PRESC_W{1'b0}};
      end else if (ce_i) begin
         presc_q <= presc_q + 1'b1;
         presc_prev_q <= presc_q;
      end
   end

   function tick_sel;
      input [3:0] sel;
      input rise;
      input fall;
      input [`DET_PRESC_W-1:0] cur;
      input [`DET_PRESC_W-1:0] prv;
      reg [3:0] tap;
      begin
         tap = sel - `DET_CSEL_INT_MIN;
         if (sel == `DET_CSEL_EVT_FALL) begin
            tick_sel = fall;
         end else if (sel == `DET_CSEL_EVT_RISE) begin
            tick_sel = rise;
         end else if (sel < `DET_CSEL_INT_MIN) begin
            tick_sel = 1'b0;
         end else if (tap == 4'h0) begin
            tick_sel = 1'b1;
         end else begin
            // Rising edge of prescaler bit tap-1 gives clk/2^tap
            tick_sel = cur[tap-4'h1] & ~prv[tap-4'h1];
         end
      end
   endfunction

   // ************************************************
   // Tick selection and match decode
   // ************************************************
   reg low_tick;
   reg high_tick_own;
   reg high_tick;
   reg low_hit;
   reg low_wrap;
   reg high_own_hit;
   reg cas_hit;
   reg high_hit;
   reg low_fire;

   reg [CNT_W-1:0] low_next;
   reg [CNT_W-1:0] high_next;

   // Zero compare matches every tick, so outside cascade mode the counter never leaves zero
   function hit_at;
      input [CNT_W-1:0] nxt;
      input [CNT_W-1:0] cmp;
      begin
         hit_at = (nxt == cmp) | (cmp == {CNT_W{1'b0}});
      end
   endfunction

   // Match is tested on the value reached after the tick, so the counter
   // clears instead of ever showing the compare value when not in cascade mode
   always @* begin
      low_tick = ce_i & count_enable_bit_i &
         tick_sel(clock_select_reg_i, evt_rise, evt_fall, presc_q, presc_prev_q);
      high_tick_own = ce_i & count_enable_bit_i &
         tick_sel(high_clock_select_i, evt_rise, evt_fall, presc_q, presc_prev_q);
      low_next = low_counter_o + {{(CNT_W-1){1'b0}}, 1'b1};
      high_next = high_counter_o + {{(CNT_W-1){1'b0}}, 1'b1};
      low_hit = hit_at(low_next, low_compare_o);
      low_wrap = (low_next == {CNT_W{1'b0}});
      high_own_hit = hit_at(high_next, high_compare_o);
      // 16-bit match needs both halves; the high half is compared as it stands
      cas_hit = low_tick & (low_next == low_compare_o) &
         (high_counter_o == high_compare_o);
      low_fire = low_tick & low_hit;
      if (cascade_i) begin
         // High steps only when the low half wraps
         high_tick = low_tick & low_wrap;
         high_hit = cas_hit;
      end else begin
         high_tick = high_tick_own;
         high_hit = high_tick_own & high_own_hit;
      end
   end

   // ************************************************
   // Compare registers
   // ************************************************
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         low_compare_o <= `DET_CMP_RST;
         high_compare_o <= `DET_CMP_RST;
      end else if (ce_i) begin
         // Any value including zero is stored; cascade writes rely on a stopped timer
         if (low_compare_wr_i) begin
            low_compare_o <= compare_wdata_i;
         end
         if (high_compare_wr_i) begin
            high_compare_o <= compare_wdata_i;
         end
      end
   end

   // ************************************************
   // Counters
   // ************************************************
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         low_counter_o <= `DET_CNT_RST;
         high_counter_o <= `DET_CNT_RST;
      end else if (ce_i) begin
         if (!count_enable_bit_i) begin
            // Stopping clears the counts, so a restart always begins from zero
            low_counter_o <= `DET_CNT_RST;
            high_counter_o <= `DET_CNT_RST;
         end else if (cascade_i) begin
            if (cas_hit) begin
               low_counter_o <= `DET_CNT_RST;
               high_counter_o <= `DET_CNT_RST;
            end else if (low_tick) begin
               low_counter_o <= low_next;
               if (high_tick) begin
                  high_counter_o <= high_next;
               end
            end
         end else begin
            // A compare lowered below the count is passed; the count wraps through zero
            if (low_fire) begin
               low_counter_o <= `DET_CNT_RST;
            end else if (low_tick) begin
               low_counter_o <= low_next;
            end
            if (high_hit) begin
               high_counter_o <= `DET_CNT_RST;
            end else if (high_tick) begin
               high_counter_o <= high_next;
            end
         end
      end
   end

   // ************************************************
   // Match requests and output toggles
   // ************************************************
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         low_match_irq_o <= 1'b0;
         high_match_irq_o <= 1'b0;
         low_timer_output_o <= 1'b0;
         high_timer_output_o <= 1'b0;
      end else if (ce_i) begin
         // High for one cycle per match, back-to-back matches hold them high; the low half still reports in cascade mode
         low_match_irq_o <= low_fire;
         high_match_irq_o <= high_hit;
         if (low_fire) begin
            low_timer_output_o <= ~low_timer_output_o;
         end
         if (high_hit) begin
            high_timer_output_o <= ~high_timer_output_o;
         end
      end
   end
endmodule

// ==== verification/det_props.sv ====
`timescale 1ns/1ps
module det_props (
   // Clock and reset
   input wire clk_sys_i,
   input wire srst_i,
   // Observed ports
   input wire ce_i,
   input wire count_enable_bit_i,
   input wire cascade_i,
   input wire low_compare_wr_i,
   input wire [7:0] compare_wdata_i,
   input wire [7:0] low_counter_o,
   input wire [7:0] low_compare_o,
   input wire low_match_irq_o,
   input wire low_timer_output_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);
   a_irq_clears_cnt: assert property (low_match_irq_o && !cascade_i |-> low_counter_o == 8'h00)
      else $error("counter not cleared on match");
   a_irq_toggles_out: assert property (low_match_irq_o |->
      low_timer_output_o != $past(low_timer_output_o)) else $error("output not toggled");
   a_cmp_write: assert property (low_compare_wr_i && ce_i |=>
      low_compare_o == $past(compare_wdata_i)) else $error("compare not written");
   a_cmp_hold: assert property (!low_compare_wr_i |=> $stable(low_compare_o))
      else $error("compare changed without write");
   a_cnt_step_one: assert property ($changed(low_counter_o) |->
      low_counter_o == $past(low_counter_o) + 8'h01 || low_counter_o == 8'h00)
      else $error("counter jumped");
   a_stop_holds_zero: assert property (!count_enable_bit_i |=> low_counter_o == 8'h00)
      else $error("stopped counter not zero");
   a_stop_no_irq: assert property (!count_enable_bit_i [*2] |-> !low_match_irq_o)
      else $error("match while stopped");
   a_clear_by_match: assert property (low_counter_o == 8'h00 && $past(count_enable_bit_i)
      && $past(low_counter_o) != 8'h00 && $past(low_counter_o) != 8'hFF |->
      low_match_irq_o) else $error("counter cleared without match");
   c_match: cover property (low_match_irq_o);
   c_zero_match: cover property (low_match_irq_o && low_compare_o == 8'h00);
   c_cascade_match: cover property (cascade_i && low_match_irq_o);
endmodule
bind det_timer det_props u_det_props (.clk_sys_i, .srst_i, .ce_i, .count_enable_bit_i,
   .cascade_i, .low_compare_wr_i, .compare_wdata_i, .low_counter_o, .low_compare_o,
   .low_match_irq_o, .low_timer_output_o);

// ==== verification/det_pin_src.sv ====
`timescale 1ns/1ps
module det_pin_src (
   input wire clk_sys_i,
   output reg pin_o
);
   initial pin_o = 1'b0;
   // Each level stands four cycles so the synchroniser sees every edge
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_sys_i);
         #1 pin_o = 1'b1;
         repeat (4) @(posedge clk_sys_i);
         #1 pin_o = 1'b0;
      end
   endtask
endmodule

// ==== verification/dual_8bit_cascadable_event_timer_bench.sv ====
`timescale 1ns/1ps
module dual_8bit_cascadable_event_timer_bench;
   reg clk_sys_i = 0, srst_i = 1, en = 0, cas = 0, lw = 0, hw = 0;
   reg [3:0] sel = 4'h4;
   reg [3:0] hsel = 4'h0;
   reg [7:0] wd = 8'h00, irqs = 8'h00, hirqs = 8'h00;
   wire pin, lirq, hirq, lto, hto;
   wire [7:0] lcnt, hcnt, lcmp, hcmp;
   int err_count = 0, tests_run = 0, n;
   initial forever #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (lirq === 1'b1) irqs <= irqs + 8'h01;
   always @(posedge clk_sys_i) if (hirq === 1'b1) hirqs <= hirqs + 8'h01;
   det_pin_src u_det_pin_src (.clk_sys_i, .pin_o(pin));
   det_timer u_det_timer (.clk_sys_i, .srst_i, .ce_i(1'b1), .count_enable_bit_i(en),
      .cascade_i(cas), .clock_select_reg_i(sel), .high_clock_select_i(hsel),
      .low_compare_wr_i(lw), .high_compare_wr_i(hw), .compare_wdata_i(wd),
      .event_input_pin_i(pin), .low_counter_o(lcnt), .high_counter_o(hcnt),
      .low_compare_o(lcmp), .high_compare_o(hcmp), .low_match_irq_o(lirq),
      .high_match_irq_o(hirq), .low_timer_output_o(lto), .high_timer_output_o(hto));
   task automatic test_done;
      $display("tests %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input [7:0] got, input [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wcmp(input bit h, input [7:0] d);
      wd = d;
      lw = !h;
      hw = h;
      tick(1);
      lw = 0;
      hw = 0;
      tick(1);
   endtask
   // Bounded wait for a match pulse, c is the cycle count
   task automatic wirq(input bit h, output int c);
      c = 0;
      do begin
         tick(1);
         c++;
      end while ((h ? hirq : lirq) !== 1'b1 && c < 2000);
      if ((h ? hirq : lirq) !== 1'b1) begin
         err_count++;
         test_done();
      end
   endtask
   task automatic t_interval;
      reg t0;
      wcmp(0, 8'h02);
      en = 1;
      wirq(0, n);
      t0 = lto;
      wirq(0, n);
      cmp(n[7:0], 8'h02);
      cmp(lcnt, 8'h00);
      cmp({7'h00, lto}, {7'h00, ~t0});
      en = 0;
      $display("interval test done");
   endtask
   task automatic t_events(input [3:0] s, input [7:0] c, input [7:0] exp);
      reg [7:0] lb;
      reg [7:0] hb;
      sel = s;
      wcmp(0, c);
      cmp(lcmp, c);
      en = 1;
      lb = irqs;
      hb = hirqs;
      u_det_pin_src.pulses(6);
      tick(6);
      cmp(irqs - lb, exp);
      cmp(hirqs - hb, 8'h06);
      en = 0;
      $display("event test done");
   endtask
   task automatic t_wrap;
      sel = 4'h4;
      wcmp(0, 8'hC0);
      en = 1;
      tick(64);
      // Lowered below the count: the counter must pass 8'hFF before matching
      wcmp(0, 8'h10);
      wirq(0, n);
      cmp({7'h00, n > 180 && n < 220}, 8'h01);
      // Restarting after the lowering write avoids the long wrap
      wcmp(0, 8'hC0);
      tick(64);
      wcmp(0, 8'h10);
      en = 0;
      tick(1);
      en = 1;
      wirq(0, n);
      cmp(n[7:0], 8'h10);
      en = 0;
      $display("wrap test done");
   endtask
   task automatic t_cascade;
      reg t0;
      reg [7:0] lb;
      cas = 1;
      wcmp(0, 8'h02);
      wcmp(1, 8'h01);
      cmp(hcmp, 8'h01);
      en = 1;
      wirq(1, n);
      t0 = hto;
      lb = irqs;
      wirq(1, n);
      cmp(n[15:8], 8'h01);
      cmp(n[7:0], 8'h02);
      cmp(hcnt, 8'h00);
      cmp({7'h00, hto}, {7'h00, ~t0});
      cmp(irqs - lb, 8'h02);
      en = 0;
      cas = 0;
      $display("cascade test done");
   endtask
   initial begin
      tick(2);
      srst_i = 0;
      t_interval();
      t_events(4'h1, 8'h00, 8'h06);
      t_events(4'h0, 8'h02, 8'h03);
      t_wrap();
      t_cascade();
      test_done();
   end
endmodule
